// ===== five_channel_reload_timer_pkg.sv
// constants, register map and field layout of the five channel reload timer
// assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock
package five_channel_reload_timer_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH        = 5;
  localparam int NLO        = 3;
  localparam int START_LO_W = 3;
  localparam int START_HI_W = 2;
  localparam int PRESC_W    = 10;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_START_HI   = 32'hfe10_0004;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hfe10_0020;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'hfe10_0024;
  localparam logic [31:0] ADDR_PIN_CTL    = 32'hffd8_0000;
  localparam logic [31:0] ADDR_START_LO   = 32'hffd8_0004;
  localparam logic [31:0] ADDR_CAPTURE2   = 32'hffd8_002c;
  localparam logic [NCH-1:0][31:0] ADDR_RELOAD = {32'hfe10_0014, 32'hfe10_0008,
    32'hffd8_0020, 32'hffd8_0014, 32'hffd8_0008};
  localparam logic [NCH-1:0][31:0] ADDR_COUNT  = {32'hfe10_0018, 32'hfe10_000c,
    32'hffd8_0024, 32'hffd8_0018, 32'hffd8_000c};
  localparam logic [NCH-1:0][31:0] ADDR_CTRL   = {32'hfe10_001c, 32'hfe10_0010,
    32'hffd8_0028, 32'hffd8_001c, 32'hffd8_0010};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] COUNT_INIT = 32'h0fff_ffff;
  localparam logic [15:0] CTRL_INIT  = 16'h0000;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_SRC_LSB  = 0;
  localparam int CTL_EDGE_LSB = 3;
  localparam int CTL_ICPE1    = 7;
  localparam int CTL_UNF      = 8;
  localparam int CTL_ICPF     = 9;
  localparam logic [15:0] CTL_MASK_CH01 = 16'h013f;
  localparam logic [15:0] CTL_MASK_CH2  = 16'h03ff;
  localparam logic [15:0] CTL_MASK_CH34 = 16'h0127;
  localparam logic [2:0]  SRC_RTC       = 3'h5;
  localparam logic [2:0]  SRC_EXT       = 3'h6;
  localparam logic [2:0]  SRC_INT_LAST  = 3'h4;
  localparam logic [1:0]  EDGE_RISE     = 2'h0;
  localparam logic [1:0]  EDGE_FALL     = 2'h1;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== reload_down_counter.sv
// one auto-reload 32-bit down-counter channel
// assumes tick is a one-cycle enable and init is a synchronous re-init level
`timescale 1ns/10ps
module reload_down_counter
  import five_channel_reload_timer_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         init,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic         load_we,
  input  wire logic [W-1:0] load_data,
  input  wire logic [W-1:0] reload_value,
  output logic      [W-1:0] count,
  output logic              underflow
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         underflow;
  } cnt_state_s;

  cnt_state_s q;
  cnt_state_s next_q;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  always_comb begin
    next_q           = q;
    next_q.underflow = 1'b0;
    if (init) begin
      next_q.count = W'(COUNT_INIT);
    end else if (load_we) begin
      next_q.count = load_data;
    end else if (run && tick) begin
      if (q.count == '0) begin
        next_q.count     = reload_value;
        next_q.underflow = 1'b1;
      end else begin
        next_q.count = q.count - W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q.count     <= W'(COUNT_INIT);
      q.underflow <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  assign count     = q.count;
  assign underflow = q.underflow;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reload_on_wrap: assert property (
    run && tick && q.count == '0 && !load_we && !init
      |=> q.underflow && q.count == $past(reload_value))
    else $error("underflow did not reload the constant");

  a_step_down: assert property (
    run && tick && q.count != '0 && !load_we && !init
      |=> q.count == $past(q.count) - W'(1) && !q.underflow)
    else $error("counter did not step down by one");

endmodule

// ===== five_channel_reload_timer.sv
// five channel auto-reload timer with an AXI4-Lite register slave
// assumes pins manual_rst_pin, standby_pin, hw_standby_pin and the rtc clock are
// asynchronous to clk; the pad logic resolves the timer clock pin from its enable
//
// How it works
// - pin-output select 0 makes the timer clock pin an input, 1 drives rtc clock
// - reserved bits of pin control and start registers read zero, writes ignored
// - pin control clears on power-on or manual reset, holds in standby
// - start bits 0..2 run channels 0..2 when one, halt when zero
// - first start register clears on resets; standby clears non-rtc channels only
// - start bits 0 and 1 of second register run channels 3 and 4
// - second start register clears only on power-on reset
// - channels 3 and 4 pause during standby and resume afterwards
// - underflow reloads the counter from its reload constant and keeps counting
// - each channel has a 32-bit read/write reload constant
// - reload constants 0..2 initialise on power-on or manual reset
// - reload constants 3 and 4 initialise on power-on reset only
// - channels 0..2 on the rtc clock keep counting in standby
// - driving rtc clock: pin low in standby, released in hardware standby
// - underflow sets that channel's underflow flag in its control register
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module five_channel_reload_timer
  import five_channel_reload_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        manual_rst_pin,
  input  wire logic        standby_pin,
  input  wire logic        hw_standby_pin,
  input  wire logic        rtc_output_clock,
  input  wire logic        timer_clock_pin_in,
  output logic             timer_clock_pin_out,
  output logic             timer_clock_pin_oe_n,
  output logic             irq,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
    logic                      aw_got;
    logic [31:0]               aw_addr;
    logic                      w_got;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      out_sel;
    logic [START_LO_W-1:0]     start_lo;
    logic [START_HI_W-1:0]     start_hi;
    logic [NCH-1:0][31:0]      reload;
    logic [NCH-1:0][15:0]      ctrl;
    logic [31:0]               capture;
    logic [NCH-1:0]            irq_status;
    logic [NCH-1:0]            irq_mask;
    logic                      irq;
    logic                      pin_out;
    logic                      pin_oe_n;
    logic [PRESC_W-1:0]        presc;
    logic [1:0]                ext_s;
    logic                      ext_prev;
    logic [1:0]                rtc_s;
    logic                      rtc_prev;
    logic [1:0]                man_s;
    logic [1:0]                stby_s;
    logic [1:0]                hw_s;
  } state_s;

  state_s               q;
  state_s               next_q;
  logic [NCH-1:0]       tick;
  logic [NCH-1:0]       run;
  logic [NCH-1:0]       cnt_we;
  logic [NCH-1:0][31:0] cnt_val;
  logic [NCH-1:0]       uf;
  logic                 wr_go;
  logic                 wr_hit;
  logic                 man_rst;
  logic                 stby;
  logic                 hw_stby;
  logic                 rtc_tick;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // internal divider taps: sel 0..4 pick clk/4, /16, /64, /256, /1024
  function automatic logic int_tick(input logic [2:0] sel, input logic [PRESC_W-1:0] p);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((11'h004 << (2 * sel)) - 11'h001);
    return (p & m) == m;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
    logic r;
    case (sel)
      EDGE_RISE: r = cur & ~prev;
      EDGE_FALL: r = ~cur & prev;
      default:   r = cur ^ prev;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] ctrl_mask(input int ch);
    return (ch == 2) ? CTL_MASK_CH2 : (ch < NLO) ? CTL_MASK_CH01 : CTL_MASK_CH34;
  endfunction

  // ----------------------------------------------------------------
  // channel counters
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    reload_down_counter #(
      .W (32)
    ) u_cnt (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .init         ((c < NLO) ? man_rst : 1'b0),
      .tick         (tick[c]),
      .run          (run[c]),
      .load_we      (cnt_we[c]),
      .load_data    (merge(cnt_val[c], q.w_data, q.w_strb)),
      .reload_value (q.reload[c]),
      .count        (cnt_val[c]),
      .underflow    (uf[c])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic [2:0]  src;
    rd      = '0;
    hit     = 1'b0;
    src     = '0;
    next_q  = q;
    man_rst = q.man_s[1];
    stby    = q.stby_s[1];
    hw_stby = q.hw_s[1];
    rtc_tick = q.rtc_s[1] & ~q.rtc_prev;
    wr_go   = q.aw_got && q.w_got && !q.bvalid;
    wr_hit  = 1'b0;
    cnt_we  = '0;

    // pin synchronisers; first stage only feeds the second
    next_q.ext_s    = {q.ext_s[0], timer_clock_pin_in};
    next_q.ext_prev = q.ext_s[1];
    next_q.rtc_s    = {q.rtc_s[0], rtc_output_clock};
    next_q.rtc_prev = q.rtc_s[1];
    next_q.man_s    = {q.man_s[0], manual_rst_pin};
    next_q.stby_s   = {q.stby_s[0], standby_pin};
    next_q.hw_s     = {q.hw_s[0], hw_standby_pin};
    next_q.presc    = q.presc + PRESC_W'(1);

    // tick and run per channel
    for (int c = 0; c < NCH; c++) begin
      src = q.ctrl[c][CTL_SRC_LSB +: 3];
      if (src <= SRC_INT_LAST) begin
        tick[c] = int_tick(src, q.presc);
      end else if (c < NLO && src == SRC_RTC) begin
        tick[c] = rtc_tick;
      end else if (c < NLO && src >= SRC_EXT) begin
        // external edges count only while the pin is an input
        tick[c] = !q.out_sel && edge_hit(q.ctrl[c][CTL_EDGE_LSB +: 2],
                                         q.ext_s[1], q.ext_prev);
      end else begin
        tick[c] = 1'b0;
      end
      if (c < NLO) begin
        run[c] = q.start_lo[c] && (!stby || src == SRC_RTC);
      end else begin
        run[c] = q.start_hi[c - NLO] && !stby;
      end
    end

    // write channel
    if (q.awready && s_axi_awvalid) begin
      next_q.aw_got  = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid) begin
      next_q.w_got  = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (wr_go) begin
      if (q.aw_addr == ADDR_PIN_CTL) begin
        wr_hit         = 1'b1;
        if (q.w_strb[0]) begin
          next_q.out_sel = q.w_data[0];
        end
      end
      if (q.aw_addr == ADDR_START_LO) begin
        wr_hit          = 1'b1;
        next_q.start_lo = START_LO_W'(merge({29'h0, q.start_lo}, q.w_data, q.w_strb));
      end
      if (q.aw_addr == ADDR_START_HI) begin
        wr_hit          = 1'b1;
        next_q.start_hi = START_HI_W'(merge({30'h0, q.start_hi}, q.w_data, q.w_strb));
      end
      if (q.aw_addr == ADDR_IRQ_MASK) begin
        wr_hit          = 1'b1;
        next_q.irq_mask = NCH'(merge({27'h0, q.irq_mask}, q.w_data, q.w_strb));
      end
      if (q.aw_addr == ADDR_IRQ_STATUS) begin
        wr_hit = 1'b1;
      end
      for (int c = 0; c < NCH; c++) begin
        if (q.aw_addr == ADDR_RELOAD[c]) begin
          wr_hit          = 1'b1;
          next_q.reload[c] = merge(q.reload[c], q.w_data, q.w_strb);
        end
        if (q.aw_addr == ADDR_COUNT[c]) begin
          wr_hit    = 1'b1;
          cnt_we[c] = 1'b1;
        end
        if (q.aw_addr == ADDR_CTRL[c]) begin
          wr_hit = 1'b1;
          next_q.ctrl[c] = 16'(merge({16'h0, q.ctrl[c]}, q.w_data, q.w_strb))
                           & ctrl_mask(c);
          // flags clear on a zero write and keep their value on a one
          next_q.ctrl[c][CTL_UNF]  = q.ctrl[c][CTL_UNF] & next_q.ctrl[c][CTL_UNF];
          next_q.ctrl[c][CTL_ICPF] = q.ctrl[c][CTL_ICPF] & next_q.ctrl[c][CTL_ICPF];
        end
      end
      next_q.aw_got = 1'b0;
      next_q.w_got  = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // read channel; a status read clears the bits it returns
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (q.arready && s_axi_arvalid) begin
      hit = 1'b1;
      case (s_axi_araddr)
        ADDR_PIN_CTL:    rd = {31'h0, q.out_sel};
        ADDR_START_LO:   rd = {29'h0, q.start_lo};
        ADDR_START_HI:   rd = {30'h0, q.start_hi};
        ADDR_CAPTURE2:   rd = q.capture;
        ADDR_IRQ_MASK:   rd = {27'h0, q.irq_mask};
        ADDR_IRQ_STATUS: begin
          rd                = {27'h0, q.irq_status};
          next_q.irq_status = '0;
        end
        default:         hit = 1'b0;
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (s_axi_araddr == ADDR_RELOAD[c]) begin
          rd  = q.reload[c];
          hit = 1'b1;
        end
        if (s_axi_araddr == ADDR_COUNT[c]) begin
          rd  = cnt_val[c];
          hit = 1'b1;
        end
        if (s_axi_araddr == ADDR_CTRL[c]) begin
          rd  = {16'h0, q.ctrl[c]};
          hit = 1'b1;
        end
      end
      next_q.rdata  = rd;
      next_q.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
      next_q.rvalid = 1'b1;
    end

    // hardware events after software clears, so a set is never lost
    for (int c = 0; c < NCH; c++) begin
      if (uf[c]) begin
        next_q.ctrl[c][CTL_UNF] = 1'b1;
        next_q.irq_status[c]    = 1'b1;
      end
    end
    if (q.ctrl[2][CTL_ICPE1] && !q.out_sel && !q.ctrl[2][CTL_ICPF]
        && edge_hit(q.ctrl[2][CTL_EDGE_LSB +: 2], q.ext_s[1], q.ext_prev)) begin
      next_q.capture           = cnt_val[2];
      next_q.ctrl[2][CTL_ICPF] = 1'b1;
    end

    // standby drops the start bits of channels 0..2 not on the rtc clock
    if (stby) begin
      for (int c = 0; c < NLO; c++) begin
        if (q.ctrl[c][CTL_SRC_LSB +: 3] != SRC_RTC) begin
          next_q.start_lo[c] = 1'b0;
        end
      end
    end

    // manual reset touches channels 0..2 and common pin control only
    if (man_rst) begin
      next_q.out_sel  = 1'b0;
      next_q.start_lo = '0;
      for (int c = 0; c < NLO; c++) begin
        next_q.reload[c] = COUNT_INIT;
        next_q.ctrl[c]   = CTRL_INIT;
      end
    end

    // pin drive; the rtc level is only ever the synchronised copy
    if (!next_q.out_sel || hw_stby) begin
      next_q.pin_out  = 1'b0;
      next_q.pin_oe_n = 1'b1;
    end else begin
      next_q.pin_out  = stby ? 1'b0 : q.rtc_s[1];
      next_q.pin_oe_n = 1'b0;
    end

    next_q.irq     = |(next_q.irq_status & next_q.irq_mask);
    next_q.awready = !next_q.aw_got;
    next_q.wready  = !next_q.w_got;
    next_q.arready = !next_q.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q          <= '0;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
      q.pin_oe_n <= 1'b1;
      for (int c = 0; c < NCH; c++) begin
        q.reload[c] <= COUNT_INIT;
      end
    end else begin
      q <= next_q;
    end
  end

  assign timer_clock_pin_out  = q.pin_out;
  assign timer_clock_pin_oe_n = q.pin_oe_n;
  assign irq                  = q.irq;
  assign s_axi_awready        = q.awready;
  assign s_axi_wready         = q.wready;
  assign s_axi_bvalid         = q.bvalid;
  assign s_axi_bresp          = q.bresp;
  assign s_axi_arready        = q.arready;
  assign s_axi_rvalid         = q.rvalid;
  assign s_axi_rresp          = q.rresp;
  assign s_axi_rdata          = q.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pin_input_mode: assert property (
    !q.out_sel |-> q.pin_oe_n)
    else $error("pin driven while selected as input");

  a_start_read_zero: assert property (
    q.arready && s_axi_arvalid && s_axi_araddr == ADDR_START_LO
      |=> q.rvalid && q.rdata[31:START_LO_W] == '0)
    else $error("reserved start bits read non-zero");

  a_manual_init: assert property (
    man_rst |=> !q.out_sel && q.start_lo == '0 && q.reload[0] == COUNT_INIT)
    else $error("manual reset left channel 0..2 state");

  a_hi_survives: assert property (
    man_rst && !wr_go |=> q.start_hi == $past(q.start_hi)
      && q.reload[3] == $past(q.reload[3]))
    else $error("manual reset changed channel 3..4 state");

  a_standby_drop: assert property (
    stby && q.ctrl[0][CTL_SRC_LSB +: 3] != SRC_RTC |=> !q.start_lo[0])
    else $error("start bit kept in standby on non-rtc clock");

  a_hi_paused: assert property (
    stby && !cnt_we[3] |=> $stable(cnt_val[3]))
    else $error("channel 3 counted during standby");

  a_flag_on_wrap: assert property (
    uf[1] && !man_rst |=> q.ctrl[1][CTL_UNF] && q.irq_status[1])
    else $error("underflow flag not set");

  a_pin_low_stby: assert property (
    next_q.out_sel && stby && !hw_stby |=> !q.pin_oe_n && !q.pin_out)
    else $error("pin not held low in standby");

  a_irq_level: assert property (
    q.irq == |(q.irq_status & q.irq_mask))
    else $error("interrupt does not follow status and mask");

endmodule

// ===== five_channel_reload_timer_test.sv
// self-checking bench for the five channel reload timer over its AXI4-Lite slave
// assumes one 50 MHz clock; rtc and pad inputs are toggled by the tests themselves
`timescale 1ns/10ps
module five_channel_reload_timer_test import five_channel_reload_timer_pkg::*;;
  `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
  logic        clk, sys_rst, manual_rst_pin, standby_pin, hw_standby_pin, rtc_output_clock;
  logic        timer_clock_pin_in, timer_clock_pin_out, timer_clock_pin_oe_n, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv, keep;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fail_count, n_tests;
  five_channel_reload_timer dut (.clk, .sys_rst, .manual_rst_pin, .standby_pin,
    .hw_standby_pin, .rtc_output_clock, .timer_clock_pin_in, .timer_clock_pin_out,
    .timer_clock_pin_oe_n, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // channels released one by one; slave may take address and data apart
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdv, e)
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {manual_rst_pin, standby_pin, hw_standby_pin, rtc_output_clock} = 4'h0;
    {timer_clock_pin_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    fail_count = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    chk_rd(ADDR_PIN_CTL, 32'h0);
    chk_rd(ADDR_START_LO, 32'h0);
    chk_rd(ADDR_START_HI, 32'h0);
    for (int i = 0; i < NCH; i++) chk_rd(ADDR_RELOAD[i], COUNT_INIT);
    for (int i = 0; i < NCH; i++) wr(ADDR_RELOAD[i], 32'ha5c3_0000 + i);
    for (int i = 0; i < NCH; i++) chk_rd(ADDR_RELOAD[i], 32'ha5c3_0000 + i);
    wr(ADDR_PIN_CTL, 32'hffff_ffff);
    chk_rd(ADDR_PIN_CTL, 32'h1);
    `CHK(timer_clock_pin_oe_n, 1'b0)
    wr(ADDR_PIN_CTL, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(timer_clock_pin_oe_n, 1'b1)
    wr(ADDR_START_HI, 32'hffff_ffff);
    chk_rd(ADDR_START_HI, 32'h3);
    wr(ADDR_START_LO, 32'hffff_fff8);
    chk_rd(ADDR_START_LO, 32'h0);
    // ch0 on clk/4: count 1 wraps to reload 5, flag and irq follow
    wr(ADDR_RELOAD[0], 32'h5);
    wr(ADDR_COUNT[0], 32'h1);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_START_LO, 32'h1);
    repeat (12) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(ADDR_START_LO, 32'h0);
    rd(ADDR_COUNT[0]);
    keep = rdv;
    `CHK(keep <= 32'h5, 1'b1)
    repeat (20) @(posedge clk);
    chk_rd(ADDR_COUNT[0], keep);
    chk_rd(ADDR_CTRL[0], 32'h100);
    chk_rd(ADDR_IRQ_STATUS, 32'h1);
    chk_rd(ADDR_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    // unmapped place
    rd(32'hffd8_0040);
    `CHK({rsp, rdv}, {RESP_SLVERR, 32'h0})
    wr(32'hffd8_0040, 32'h1);
    `CHK(rsp, RESP_SLVERR)
    // manual reset keeps channels 3 and 4
    wr(ADDR_PIN_CTL, 32'h1);
    wr(ADDR_START_LO, 32'h7);
    manual_rst_pin <= 1'b1;
    repeat (6) @(posedge clk);
    manual_rst_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk_rd(ADDR_PIN_CTL, 32'h0);
    chk_rd(ADDR_START_LO, 32'h0);
    chk_rd(ADDR_RELOAD[0], COUNT_INIT);
    chk_rd(ADDR_RELOAD[3], 32'ha5c3_0003);
    chk_rd(ADDR_START_HI, 32'h3);
    // standby: low channels on internal clock stop, ch2 on rtc runs, ch3 pauses
    wr(ADDR_PIN_CTL, 32'h1);
    wr(ADDR_CTRL[2], 32'h5);
    wr(ADDR_START_LO, 32'h6);
    standby_pin <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({timer_clock_pin_oe_n, timer_clock_pin_out}, 2'b00)
    chk_rd(ADDR_START_LO, 32'h4);
    chk_rd(ADDR_PIN_CTL, 32'h1);
    // four rtc rising edges while in standby
    repeat (4) begin
      rtc_output_clock <= 1'b1;
      repeat (3) @(posedge clk);
      rtc_output_clock <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk_rd(ADDR_COUNT[2], COUNT_INIT - 32'h4);
    rd(ADDR_COUNT[3]);
    keep = rdv;
    repeat (20) @(posedge clk);
    chk_rd(ADDR_COUNT[3], keep);
    standby_pin <= 1'b0;
    repeat (30) @(posedge clk);
    rd(ADDR_COUNT[3]);
    `CHK(rdv < keep, 1'b1)
    chk_rd(ADDR_START_HI, 32'h3);
    // hardware standby releases the pin even while it drives the rtc clock
    hw_standby_pin <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(timer_clock_pin_oe_n, 1'b1)
    hw_standby_pin <= 1'b0;
    // pin as input: rising edges clock ch0 and capture the stopped ch2 once
    wr(ADDR_PIN_CTL, 32'h0);
    wr(ADDR_CTRL[2], 32'h85);
    wr(ADDR_CTRL[0], 32'h6);
    wr(ADDR_COUNT[0], 32'h40);
    wr(ADDR_START_LO, 32'h1);
    repeat (3) begin
      timer_clock_pin_in <= 1'b1;
      repeat (3) @(posedge clk);
      timer_clock_pin_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk_rd(ADDR_COUNT[0], 32'h3d);
    chk_rd(ADDR_CAPTURE2, COUNT_INIT - 32'h4);
    chk_rd(ADDR_CTRL[2], 32'h285);
    complete_run();
  end
endmodule
